// >>> core/uedb_pkg.sv
// Shared constants and types of the endpoint descriptor block
`default_nettype none
package uedb_pkg;
    //////////////////////////////////////////////////////////////////////
    // Endpoint range and directions
    localparam int NUM_DIR = 2;
    localparam int NUM_EP = 8;
    localparam int EP_FIRST = 1;
    localparam logic DIR_OUT = 1'b0;
    localparam logic DIR_IN = 1'b1;
    //////////////////////////////////////////////////////////////////////
    // Offsets inside one 8-byte descriptor entry (register index)
    localparam logic [2:0] OFF_CNF = 3'h0;
    localparam logic [2:0] OFF_BBX = 3'h1;
    localparam logic [2:0] OFF_BCTX = 3'h2;
    localparam logic [2:0] OFF_SPARE_A = 3'h3;
    localparam logic [2:0] OFF_SPARE_B = 3'h4;
    localparam logic [2:0] OFF_BBY = 3'h5;
    localparam logic [2:0] OFF_BCTY = 3'h6;
    localparam logic [2:0] OFF_SIZ = 3'h7;
    //////////////////////////////////////////////////////////////////////
    // Configuration byte fields
    localparam int CNF_MGR_EN = 7;
    localparam int CNF_ISO = 6;
    localparam int CNF_TOGGLE = 5;
    localparam int CNF_DOUBLE_BUFFER_ENABLE = 4;
    localparam int CNF_STALL = 3;
    localparam int CNF_IRQ_EN = 2;
    localparam logic [7:0] CNF_WMASK = 8'hFC;
    localparam logic [7:0] SIZ_WMASK = 8'h7F;
    localparam int BCT_NAK = 7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] COUNT_MAX = 7'h40;
    localparam logic [2:0] BASE_PAD = 3'h0;
    //////////////////////////////////////////////////////////////////////
    // APB map: byte address is four times the register index
    localparam int ADDR_W = 12;
    localparam logic [1:0] PAGE_DESC = 2'h0;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h81;
    localparam int IRQ_W = 16;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    //////////////////////////////////////////////////////////////////////
    // Handshake answer for the buffer manager
    typedef enum logic [1:0] {
        HS_NONE = 2'h0,
        HS_ACK = 2'h1,
        HS_NAK = 2'h3,
        HS_STALL = 2'h2
    } uedb_hs_t;
endpackage
`default_nettype wire

// >>> core/uedb_rst_sync.sv
// Reset release synchroniser for the descriptor block
`timescale 1ns/10ps
`default_nettype none
module uedb_rst_sync (
    // Clock and raw reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Synchronised reset
    output logic rst_sync_b
);
    logic meta_b;

    // Assert at once, release two edges later
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            meta_b <= 1'b1;
            rst_sync_b <= meta_b;
        end
    end
endmodule // uedb_rst_sync
`default_nettype wire

// >>> core/uedb_irq.sv
// Sticky interrupt status with mask and one level output
`timescale 1ns/10ps
`default_nettype none
module uedb_irq (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    // Events and software access
    input wire logic [uedb_pkg::IRQ_W-1:0] event_set,
    input wire logic status_we,
    input wire logic mask_we,
    input wire logic [uedb_pkg::IRQ_W-1:0] wdata,
    input wire logic [uedb_pkg::IRQ_W-1:0] wlanes,
    // State
    output logic [uedb_pkg::IRQ_W-1:0] status_reg,
    output logic [uedb_pkg::IRQ_W-1:0] mask_reg,
    output logic irq
);
    logic [uedb_pkg::IRQ_W-1:0] clear_bits;

    assign clear_bits = status_we ? (wdata & wlanes) : '0;

    // Set beats a same-cycle write-one-to-clear
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clear_bits) | event_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mask_reg <= '0;
        end else if (mask_we) begin
            mask_reg <= (mask_reg & ~wlanes) | (wdata & wlanes);
        end
    end

    assign irq = |(status_reg & mask_reg);
endmodule // uedb_irq
`default_nettype wire

// >>> core/uedb_top.sv
// Descriptor store for USB endpoints 1 to 7 with APB and manager ports
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module uedb_top (
    // System
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uedb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Buffer manager lookup
    input wire logic bm_req,
    input wire logic bm_dir,
    input wire logic [2:0] bm_ep,
    output logic bm_rsp_valid,
    output logic [1:0] bm_handshake,
    output logic bm_use_y,
    output logic bm_toggle,
    output logic [10:0] bm_start_addr,
    output logic [6:0] bm_count,
    output logic [6:0] bm_size,
    // Buffer manager completion
    input wire logic bm_done,
    input wire logic bm_done_dir,
    input wire logic [2:0] bm_done_ep,
    input wire logic bm_done_ok,
    input wire logic [6:0] bm_rx_count,
    // Buffer manager stall request
    input wire logic bm_stall_set,
    input wire logic [2:0] bm_stall_ep,
    // Interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic ep_hit(input logic dir, input logic [2:0] ep,
                                    input int d, input int e);
        return (dir == 1'(d)) && (ep == 3'(e));
    endfunction

    function automatic logic pick_y(input logic [7:0] cnf);
        return cnf[uedb_pkg::CNF_DOUBLE_BUFFER_ENABLE] & cnf[uedb_pkg::CNF_TOGGLE];
    endfunction

    function automatic logic [6:0] clamp_cnt(input logic [6:0] c);
        return (c > uedb_pkg::COUNT_MAX) ? uedb_pkg::COUNT_MAX : c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_sync_b;

    uedb_rst_sync u_rst (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .rst_sync_b(rst_sync_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // Descriptor storage, indexed [direction][endpoint]
    logic [7:0] cnf_reg [uedb_pkg::NUM_DIR][uedb_pkg::NUM_EP];
    logic [7:0] bbx_reg [uedb_pkg::NUM_DIR][uedb_pkg::NUM_EP];
    logic [7:0] bctx_reg [uedb_pkg::NUM_DIR][uedb_pkg::NUM_EP];
    logic [7:0] bby_reg [uedb_pkg::NUM_DIR][uedb_pkg::NUM_EP];
    logic [7:0] bcty_reg [uedb_pkg::NUM_DIR][uedb_pkg::NUM_EP];
    logic [7:0] siz_reg [uedb_pkg::NUM_DIR][uedb_pkg::NUM_EP];
    logic [uedb_pkg::IRQ_W-1:0] irq_event;

    ////////////////////////////////////////////////////////////////////////
    // APB address decode
    logic [7:0] a_idx;
    logic a_dir;
    logic [2:0] a_ep;
    logic [2:0] a_off;
    logic page_ok;
    logic desc_ok;
    logic stat_sel;
    logic mask_sel;
    logic addr_ok;
    logic apb_access;
    logic apb_wr;
    logic desc_wr;
    logic [7:0] pw_byte;

    assign a_idx = paddr[9:2];
    assign a_dir = a_idx[6];
    assign a_ep = a_idx[5:3];
    assign a_off = a_idx[2:0];
    assign page_ok = (paddr[11:10] == uedb_pkg::PAGE_DESC);
    // Spare slots and endpoint 0 answer with an error
    assign desc_ok = page_ok && !a_idx[7] && (a_ep != 3'h0)
                     && (a_off != uedb_pkg::OFF_SPARE_A)
                     && (a_off != uedb_pkg::OFF_SPARE_B);
    assign stat_sel = page_ok && (a_idx == uedb_pkg::IDX_IRQ_STATUS);
    assign mask_sel = page_ok && (a_idx == uedb_pkg::IDX_IRQ_MASK);
    assign addr_ok = desc_ok || stat_sel || mask_sel;
    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pwrite && addr_ok;
    assign desc_wr = apb_wr && desc_ok && pstrb[0];
    assign pw_byte = pwdata[7:0];

    // Zero wait states; error only on unmapped words
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // Per-entry update logic
    for (genvar d = 0; d < uedb_pkg::NUM_DIR; d++) begin : g_dir
        for (genvar e = 0; e < uedb_pkg::NUM_EP; e++) begin : g_ep
            localparam bit LIVE = (e >= uedb_pkg::EP_FIRST);
            localparam bit IS_IN = (d == 1);
            logic wr_sel;
            logic done_hit;
            logic stall_hit;
            logic y_now;

            assign wr_sel = LIVE && desc_wr && ep_hit(a_dir, a_ep, d, e);
            assign done_hit = LIVE && bm_done && bm_done_ok
                              && ep_hit(bm_done_dir, bm_done_ep, d, e);
            assign stall_hit = LIVE && IS_IN && bm_stall_set
                               && (bm_stall_ep == 3'(e));
            assign y_now = pick_y(cnf_reg[d][e]);

            // Configuration: toggle and stall updates beat software
            always_ff @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    cnf_reg[d][e] <= uedb_pkg::RST_BYTE;
                end else begin
                    if (wr_sel && a_off == uedb_pkg::OFF_CNF) begin
                        // Isochronous bit stored as written
                        cnf_reg[d][e] <= pw_byte & uedb_pkg::CNF_WMASK;
                    end
                    if (done_hit) begin
                        cnf_reg[d][e][uedb_pkg::CNF_TOGGLE] <=
                            ~cnf_reg[d][e][uedb_pkg::CNF_TOGGLE];
                    end
                    if (stall_hit) begin
                        cnf_reg[d][e][uedb_pkg::CNF_STALL] <= 1'b1;
                    end
                end
            end

            // Base addresses: software only
            always_ff @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    bbx_reg[d][e] <= uedb_pkg::RST_BYTE;
                    bby_reg[d][e] <= uedb_pkg::RST_BYTE;
                end else if (wr_sel) begin
                    if (a_off == uedb_pkg::OFF_BBX) begin
                        bbx_reg[d][e] <= pw_byte;
                    end
                    if (a_off == uedb_pkg::OFF_BBY) begin
                        bby_reg[d][e] <= pw_byte;
                    end
                end
            end

            // Shared X/Y size, top bit kept zero
            always_ff @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    siz_reg[d][e] <= uedb_pkg::RST_BYTE;
                end else if (wr_sel && a_off == uedb_pkg::OFF_SIZ) begin
                    siz_reg[d][e] <= pw_byte & uedb_pkg::SIZ_WMASK;
                end
            end

            // Byte counts and NAK flags of the X buffer
            always_ff @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    bctx_reg[d][e] <= uedb_pkg::RST_BYTE;
                end else begin
                    if (wr_sel && a_off == uedb_pkg::OFF_BCTX) begin
                        bctx_reg[d][e] <= pw_byte;
                    end
                    if (done_hit && !y_now && !IS_IN) begin
                        bctx_reg[d][e] <= {1'b1, clamp_cnt(bm_rx_count)};
                    end
                    if (done_hit && !y_now && IS_IN) begin
                        bctx_reg[d][e][uedb_pkg::BCT_NAK] <= 1'b1;
                    end
                end
            end

            // Byte counts and NAK flags of the Y buffer
            always_ff @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    bcty_reg[d][e] <= uedb_pkg::RST_BYTE;
                end else begin
                    if (wr_sel && a_off == uedb_pkg::OFF_BCTY) begin
                        bcty_reg[d][e] <= pw_byte;
                    end
                    if (done_hit && y_now && !IS_IN) begin
                        bcty_reg[d][e] <= {1'b1, clamp_cnt(bm_rx_count)};
                    end
                    if (done_hit && y_now && IS_IN) begin
                        bcty_reg[d][e][uedb_pkg::BCT_NAK] <= 1'b1;
                    end
                end
            end

            // Completion interrupt only when enabled
            assign irq_event[d * uedb_pkg::NUM_EP + e] =
                done_hit && cnf_reg[d][e][uedb_pkg::CNF_IRQ_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    logic [uedb_pkg::IRQ_W-1:0] irq_status;
    logic [uedb_pkg::IRQ_W-1:0] irq_mask;
    logic [uedb_pkg::IRQ_W-1:0] irq_lanes;

    assign irq_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    uedb_irq u_irq (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b),
        .event_set(irq_event),
        .status_we(apb_wr && stat_sel),
        .mask_we(apb_wr && mask_sel),
        .wdata(pwdata[uedb_pkg::IRQ_W-1:0]),
        .wlanes(irq_lanes),
        .status_reg(irq_status),
        .mask_reg(irq_mask),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB read data, captured in the setup cycle
    logic [7:0] rd_byte;

    always_comb begin
        case (a_off)
            uedb_pkg::OFF_CNF: rd_byte = cnf_reg[a_dir][a_ep];
            uedb_pkg::OFF_BBX: rd_byte = bbx_reg[a_dir][a_ep];
            uedb_pkg::OFF_BCTX: rd_byte = bctx_reg[a_dir][a_ep];
            uedb_pkg::OFF_BBY: rd_byte = bby_reg[a_dir][a_ep];
            uedb_pkg::OFF_BCTY: rd_byte = bcty_reg[a_dir][a_ep];
            uedb_pkg::OFF_SIZ: rd_byte = siz_reg[a_dir][a_ep];
            default: rd_byte = uedb_pkg::RST_BYTE;
        endcase
    end

    // A manager update in the setup cycle lands after the snapshot
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prdata <= uedb_pkg::RD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            if (desc_ok) begin
                prdata <= {24'h00_0000, rd_byte};
            end else if (stat_sel) begin
                prdata <= {16'h0000, irq_status};
            end else if (mask_sel) begin
                prdata <= {16'h0000, irq_mask};
            end else begin
                prdata <= uedb_pkg::RD_ZERO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer manager lookup
    logic [7:0] lk_cnf;
    logic lk_y;
    logic [7:0] lk_bct;
    logic [7:0] lk_base;
    logic lk_live;
    uedb_pkg::uedb_hs_t lk_hs;

    assign lk_cnf = cnf_reg[bm_dir][bm_ep];
    assign lk_y = pick_y(lk_cnf);
    assign lk_bct = lk_y ? bcty_reg[bm_dir][bm_ep] : bctx_reg[bm_dir][bm_ep];
    assign lk_base = lk_y ? bby_reg[bm_dir][bm_ep] : bbx_reg[bm_dir][bm_ep];
    assign lk_live = (bm_ep != 3'h0);

    // Disabled endpoint gets no answer; stall outranks NAK
    always_comb begin
        if (!lk_live || !lk_cnf[uedb_pkg::CNF_MGR_EN]) begin
            lk_hs = uedb_pkg::HS_NONE;
        end else if (lk_cnf[uedb_pkg::CNF_STALL]) begin
            lk_hs = uedb_pkg::HS_STALL;
        end else if (lk_bct[uedb_pkg::BCT_NAK]) begin
            lk_hs = uedb_pkg::HS_NAK;
        end else begin
            lk_hs = uedb_pkg::HS_ACK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bm_rsp_valid <= 1'b0;
        end else begin
            bm_rsp_valid <= bm_req;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bm_handshake <= uedb_pkg::HS_NONE;
            bm_use_y <= 1'b0;
            bm_toggle <= 1'b0;
            bm_start_addr <= '0;
            bm_count <= '0;
            bm_size <= '0;
        end else if (bm_req) begin
            bm_handshake <= lk_hs;
            bm_use_y <= lk_y;
            bm_toggle <= lk_cnf[uedb_pkg::CNF_TOGGLE];
            bm_start_addr <= {lk_base, uedb_pkg::BASE_PAD};
            bm_count <= clamp_cnt(lk_bct[6:0]);
            bm_size <= clamp_cnt(siz_reg[bm_dir][bm_ep][6:0]);
        end
    end
endmodule // uedb_top
`default_nettype wire

// >>> test/uedb_checker.sv
// Port assertions of the endpoint descriptor block
`timescale 1ns/10ps
`default_nettype none
module uedb_checker (
    // System
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic [uedb_pkg::ADDR_W-1:0] paddr,
    // Manager lookup
    input wire logic bm_req,
    input wire logic [2:0] bm_ep,
    input wire logic bm_rsp_valid,
    input wire logic [1:0] bm_handshake,
    input wire logic bm_use_y,
    input wire logic bm_toggle,
    input wire logic [10:0] bm_start_addr,
    input wire logic [6:0] bm_count,
    input wire logic [6:0] bm_size
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    chk_rsp_next: assert property (bm_req |=> bm_rsp_valid)
        else $error("lookup answer missing");
    chk_rsp_only: assert property (!bm_req |=> !bm_rsp_valid)
        else $error("unrequested lookup answer");
    // Answer data stands until the next request
    chk_hold_data: assert property (!bm_req |=> $stable(bm_start_addr)
        && $stable(bm_count) && $stable(bm_handshake))
        else $error("lookup data changed without request");
    chk_addr_pad: assert property (bm_rsp_valid |->
        bm_start_addr[2:0] == uedb_pkg::BASE_PAD)
        else $error("start address low bits not zero");
    chk_count_max: assert property (bm_rsp_valid |->
        bm_count <= uedb_pkg::COUNT_MAX)
        else $error("count above 64");
    chk_size_max: assert property (bm_rsp_valid |->
        bm_size <= uedb_pkg::COUNT_MAX)
        else $error("size above 64");
    chk_ep0_none: assert property (bm_req && bm_ep == 3'h0 |=>
        bm_handshake == uedb_pkg::HS_NONE)
        else $error("endpoint 0 answered");
    chk_y_toggle: assert property (bm_rsp_valid && bm_use_y |-> bm_toggle)
        else $error("Y buffer chosen with toggle 0");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    chk_ep0_err: assert property (psel && penable && !paddr[9]
        && paddr[7:5] == 3'h0 |-> pslverr)
        else $error("endpoint 0 access without error");
    cover property (bm_rsp_valid && bm_handshake == uedb_pkg::HS_STALL);
    cover property (bm_rsp_valid && bm_use_y);
    cover property (pslverr);
endmodule // uedb_checker
bind uedb_top uedb_checker u_chk (.clk_sys, .rst_b, .psel, .penable,
    .pslverr, .paddr, .bm_req, .bm_ep, .bm_rsp_valid, .bm_handshake, .bm_use_y,
    .bm_toggle, .bm_start_addr, .bm_count, .bm_size);
`default_nettype wire

// >>> test/uedb_bm_model.sv
// Behavioural buffer manager: lookups, completions and stall requests
`timescale 1ns/10ps
`default_nettype none
module uedb_bm_model (
    // Clock
    input wire logic clk_sys,
    // Lookup
    output logic bm_req,
    output logic bm_dir,
    output logic [2:0] bm_ep,
    // Completion
    output logic bm_done,
    output logic bm_done_dir,
    output logic [2:0] bm_done_ep,
    output logic bm_done_ok,
    output logic [6:0] bm_rx_count,
    // Stall request
    output logic bm_stall_set,
    output logic [2:0] bm_stall_ep
);
    initial begin
        {bm_req, bm_dir, bm_ep, bm_done, bm_done_dir, bm_done_ep} = '0;
        {bm_done_ok, bm_rx_count, bm_stall_set, bm_stall_ep} = '0;
    end
    // Base addresses are only read back, never written here
    task automatic lookup(input logic d, input logic [2:0] e);
        @(posedge clk_sys);
        {bm_req, bm_dir, bm_ep} <= {1'b1, d, e};
        @(posedge clk_sys);
        bm_req <= 1'b0;
        #1;
    endtask
    // Received counts stay within 0 to 64
    task automatic complete(input logic d, input logic [2:0] e,
                            input logic ok, input logic [6:0] n);
        @(posedge clk_sys);
        {bm_done, bm_done_dir, bm_done_ep, bm_done_ok, bm_rx_count} <=
            {1'b1, d, e, ok, n};
        @(posedge clk_sys);
        bm_done <= 1'b0;
        #1;
    endtask
    // Stall is raised by the manager on IN endpoints only
    task automatic stall(input logic [2:0] e);
        @(posedge clk_sys);
        {bm_stall_set, bm_stall_ep} <= {1'b1, e};
        @(posedge clk_sys);
        bm_stall_set <= 1'b0;
        #1;
    endtask
endmodule // uedb_bm_model
`default_nettype wire

// >>> test/uedb_tb_top.sv
// Self-checking testbench of the endpoint descriptor block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module uedb_tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, rerr, irq;
    logic bm_req, bm_dir, bm_done, bm_done_dir, bm_done_ok, bm_stall_set;
    logic [2:0] bm_ep, bm_done_ep, bm_stall_ep;
    logic [6:0] bm_rx_count, bm_count, bm_size;
    logic bm_rsp_valid, bm_use_y, bm_toggle;
    logic [1:0] bm_handshake;
    logic [10:0] bm_start_addr;
    int n_fail = 0, n_tests = 0;

    uedb_top dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .bm_req, .bm_dir,
        .bm_ep, .bm_rsp_valid, .bm_handshake, .bm_use_y, .bm_toggle,
        .bm_start_addr, .bm_count, .bm_size, .bm_done, .bm_done_dir,
        .bm_done_ep, .bm_done_ok, .bm_rx_count, .bm_stall_set,
        .bm_stall_ep, .irq);
    uedb_bm_model bm (.clk_sys, .bm_req, .bm_dir, .bm_ep, .bm_done,
        .bm_done_dir, .bm_done_ep, .bm_done_ok, .bm_rx_count,
        .bm_stall_set, .bm_stall_ep);

    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] ea(input logic d, input logic [2:0] e,
                                       input logic [2:0] o);
        return {3'h0, d, e, o, 2'h0};
    endfunction
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register", {24'h0, e}, rdat)
    endtask
    task automatic lk(input logic d, input logic [2:0] e, input logic [1:0] hs,
                      input logic [10:0] ad, input logic [6:0] n);
        bm.lookup(d, e);
        `CHK("rsp_valid", 1'b1, bm_rsp_valid)
        `CHK("handshake", hs, bm_handshake)
        `CHK("start_addr", ad, bm_start_addr)
        `CHK("count", n, bm_count)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rc(ea(1'b1, 3'h3, uedb_pkg::OFF_CNF), 8'h00);
        rc(ea(1'b0, 3'h7, uedb_pkg::OFF_SIZ), 8'h00);
        `CHK("irq", 1'b0, irq)
        `CHK("pready", 1'b1, pready)
        $display("test reset done");
    endtask
    task automatic t_regs;
        wr(ea(1'b1, 3'h7, uedb_pkg::OFF_CNF), 8'hBF);
        rc(ea(1'b1, 3'h7, uedb_pkg::OFF_CNF), 8'hBC);
        wr(ea(1'b1, 3'h7, uedb_pkg::OFF_SIZ), 8'hFF);
        rc(ea(1'b1, 3'h7, uedb_pkg::OFF_SIZ), 8'h7F);
        wr(ea(1'b0, 3'h7, uedb_pkg::OFF_BCTY), 8'hC0);
        rc(ea(1'b0, 3'h7, uedb_pkg::OFF_BCTY), 8'hC0);
        apb(1'b0, ea(1'b0, 3'h7, uedb_pkg::OFF_SPARE_A), 32'h0);
        `CHK("spare_err", 1'b1, rerr)
        `CHK("spare_data", 32'h0, rdat)
        apb(1'b1, ea(1'b0, 3'h0, uedb_pkg::OFF_CNF), 32'hFF);
        `CHK("ep0_err", 1'b1, rerr)
        $display("test registers done");
    endtask
    task automatic t_out;
        apb(1'b1, 12'h204, 32'h0000_FFFF);
        wr(ea(1'b0, 3'h2, uedb_pkg::OFF_BBX), 8'h12);
        wr(ea(1'b0, 3'h2, uedb_pkg::OFF_CNF), 8'h84);
        lk(1'b0, 3'h2, uedb_pkg::HS_ACK, 11'h090, 7'h00);
        bm.complete(1'b0, 3'h2, 1'b1, 7'h40);
        `CHK("irq_set", 1'b1, irq)
        rc(ea(1'b0, 3'h2, uedb_pkg::OFF_BCTX), 8'hC0);
        rc(ea(1'b0, 3'h2, uedb_pkg::OFF_BBX), 8'h12);
        rc(ea(1'b0, 3'h2, uedb_pkg::OFF_CNF), 8'hA4);
        lk(1'b0, 3'h2, uedb_pkg::HS_NAK, 11'h090, 7'h40);
        apb(1'b1, 12'h200, 32'h0000_0004);
        // Status clears at the access edge; look once it has settled
        @(negedge clk_sys);
        `CHK("irq_clear", 1'b0, irq)
        wr(ea(1'b0, 3'h2, uedb_pkg::OFF_CNF), 8'hB0);
        bm.complete(1'b0, 3'h2, 1'b1, 7'h10);
        rc(ea(1'b0, 3'h2, uedb_pkg::OFF_BCTY), 8'h90);
        rc(ea(1'b0, 3'h2, uedb_pkg::OFF_BCTX), 8'hC0);
        $display("test out done");
    endtask
    task automatic t_double_buffer_enable;
        wr(ea(1'b1, 3'h5, uedb_pkg::OFF_BBX), 8'h20);
        wr(ea(1'b1, 3'h5, uedb_pkg::OFF_BBY), 8'h30);
        wr(ea(1'b1, 3'h5, uedb_pkg::OFF_BCTX), 8'h05);
        wr(ea(1'b1, 3'h5, uedb_pkg::OFF_BCTY), 8'h06);
        wr(ea(1'b1, 3'h5, uedb_pkg::OFF_CNF), 8'h90);
        lk(1'b1, 3'h5, uedb_pkg::HS_ACK, 11'h100, 7'h05);
        `CHK("use_y0", 1'b0, bm_use_y)
        bm.complete(1'b1, 3'h5, 1'b1, 7'h00);
        `CHK("irq_gated", 1'b0, irq)
        rc(ea(1'b1, 3'h5, uedb_pkg::OFF_BCTX), 8'h85);
        lk(1'b1, 3'h5, uedb_pkg::HS_ACK, 11'h180, 7'h06);
        `CHK("use_y1", 1'b1, bm_use_y)
        `CHK("toggle", 1'b1, bm_toggle)
        bm.complete(1'b1, 3'h5, 1'b1, 7'h00);
        lk(1'b1, 3'h5, uedb_pkg::HS_NAK, 11'h100, 7'h05);
        $display("test double buffer done");
    endtask
    task automatic t_stall;
        bm.stall(3'h5);
        lk(1'b1, 3'h5, uedb_pkg::HS_STALL, 11'h100, 7'h05);
        rc(ea(1'b1, 3'h5, uedb_pkg::OFF_CNF), 8'h98);
        lk(1'b1, 3'h5, uedb_pkg::HS_STALL, 11'h100, 7'h05);
        wr(ea(1'b1, 3'h5, uedb_pkg::OFF_CNF), 8'h90);
        lk(1'b1, 3'h5, uedb_pkg::HS_NAK, 11'h100, 7'h05);
        bm.lookup(1'b0, 3'h4);
        `CHK("disabled_hs", uedb_pkg::HS_NONE, bm_handshake)
        bm.lookup(1'b1, 3'h0);
        `CHK("ep0_hs", uedb_pkg::HS_NONE, bm_handshake)
        bm.lookup(1'b1, 3'h7);
        `CHK("ep7_hs", uedb_pkg::HS_STALL, bm_handshake)
        `CHK("size", 7'h40, bm_size)
        $display("test stall done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Whole run is under two hundred cycles; this leaves wide margin
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_regs();
        t_out();
        t_double_buffer_enable();
        t_stall();
        conclude();
    end
endmodule // uedb_tb_top
`default_nettype wire
